// file: core/sram24_pkg.sv
// package for the 24-bit asynchronous static memory host controller
// assumes one 100 MHz clock, synchronous active-high reset
package sram24_pkg;
   localparam int CLK_PERIOD_PS = 10000;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 24;
   // 10 ns grade figures, in picoseconds
   localparam int CYCLE_TIME_PS = 10000;
   localparam int WRITE_DATA_SETUP_PS = 6000;
   localparam int STROBE_WIDTH_GATE_HIGH_PS = 8000;
   localparam int STROBE_WIDTH_GATE_LOW_PS = 10000;
   localparam int GATE_ACCESS_PS = 6500;
   localparam int ADDR_ACCESS_PS = 10000;
   localparam int BUS_TURN_PS = 4000;
   // least times round up, none below one cycle
   localparam int CYCLE_CYC = (CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SETUP_CYC = (WRITE_DATA_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PWE_HIGH_CYC = (STROBE_WIDTH_GATE_HIGH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PWE_LOW_CYC = (STROBE_WIDTH_GATE_LOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int READ_CYC = (ADDR_ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TURN_CYC = (BUS_TURN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 4;

   typedef struct packed {
      logic select_low_active;
      logic select_high_active;
      logic output_gate_n;
      logic write_strobe_n;
   } sram_ctl_s;

   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } sram_req_s;
endpackage

// file: core/sram24_host.sv
// host controller driving a 128K x 24 asynchronous static memory
// assumes memory pins are outside the clock domain; read data is synchronised
//
// Function
// - a write happens only while both selects are active and the strobe is low, all set up first.
// - a write ends when any qualifying control goes inactive, timing measured from that edge.
// - write data stands at least 5 or 6 ns before the terminating edge.
// - write data may be released at the terminating edge, hold is zero.
// - the address stays stable until the terminating edge, hold is zero.
// - with output gate high, the strobe low pulse lasts at least 6.5 or 8 ns.
// - with output gate low, the strobe low pulse lasts at least 8 or 10 ns.
// - after the strobe rises the memory waits 2 ns before driving; the host releases by then.
// - the strobe stays high for the whole of a read cycle.
// - in a select-controlled read the address is present no later than the select.
`timescale 1ns/100ps
`default_nettype none
module sram24_host #(
   parameter int ADDR_W = sram24_pkg::ADDR_W,
   parameter int DATA_W = sram24_pkg::DATA_W
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic req_valid,
   input wire sram24_pkg::sram_req_s req,
   output logic req_ready,
   output logic rd_valid,
   output logic [DATA_W-1:0] rd_data,
   output logic [ADDR_W-1:0] word_address,
   output sram24_pkg::sram_ctl_s ctl,
   input wire logic [DATA_W-1:0] data_bus_24_in,
   output logic [DATA_W-1:0] data_bus_24_out,
   output logic data_bus_24_oe_n
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WSETUP = 3'b001,
      ST_WPULSE = 3'b010,
      ST_WEND = 3'b011,
      ST_READ = 3'b100,
      ST_SAMPLE = 3'b101,
      ST_GAP = 3'b110
   } state_e;

   localparam logic [3:0] SETUP_N = 4'(sram24_pkg::SETUP_CYC);
   localparam logic [3:0] PWE_N = 4'(sram24_pkg::PWE_HIGH_CYC);
   localparam logic [3:0] READ_N = 4'(sram24_pkg::READ_CYC + 2);
   localparam logic [3:0] GAP_N = 4'(sram24_pkg::TURN_CYC);

   state_e state, next_state;
   logic [3:0] cnt, next_cnt;
   logic [DATA_W-1:0] sync1, sync2;
   logic cnt_done;
   logic accept;
   logic in_write, in_read;
   logic next_selected;
   logic next_gate_open;
   logic next_strobe_low;
   logic next_bus_drive;

   assign cnt_done = (cnt == 4'h0);
   // only a request seen with ready high is taken, so the first edge after reset takes none
   assign accept = (state == ST_IDLE) && req_valid && req_ready;
   assign in_write = (state == ST_WSETUP) || (state == ST_WPULSE);
   assign in_read = (state == ST_READ) || (state == ST_SAMPLE);
   assign next_selected = (next_state == ST_WSETUP) || (next_state == ST_WPULSE)
                          || (next_state == ST_READ) || (next_state == ST_SAMPLE);
   assign next_gate_open = (next_state == ST_READ) || (next_state == ST_SAMPLE);
   assign next_strobe_low = (next_state == ST_WPULSE);
   assign next_bus_drive = (next_state == ST_WSETUP) || (next_state == ST_WPULSE);

   always_comb begin
      next_state = state;
      next_cnt = cnt_done ? 4'h0 : cnt - 4'h1;
      unique case (state)
         ST_IDLE: begin
            if (accept) begin
               next_state = req.write ? ST_WSETUP : ST_READ;
               next_cnt = req.write ? SETUP_N - 4'h1 : READ_N - 4'h1;
            end
         end
         ST_WSETUP: begin
            // data driven and selects active before the strobe falls
            if (cnt_done) begin
               next_state = ST_WPULSE;
               next_cnt = PWE_N - 4'h1;
            end
         end
         ST_WPULSE: begin
            if (cnt_done) begin
               next_state = ST_WEND;
               next_cnt = 4'h0;
            end
         end
         ST_WEND: begin
            next_state = ST_GAP;
            next_cnt = GAP_N - 4'h1;
         end
         ST_READ: begin
            if (cnt_done) begin
               next_state = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            next_state = ST_GAP;
            next_cnt = GAP_N - 4'h1;
         end
         ST_GAP: begin
            if (cnt_done) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_cnt = 4'h0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= ST_IDLE;
         cnt <= 4'h0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // two-stage sync on the returned bus; the pins are asynchronous to core_clk
   always_ff @(posedge core_clk) begin
      sync1 <= data_bus_24_in;
      sync2 <= sync1;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         word_address <= '0;
         data_bus_24_out <= '0;
         data_bus_24_oe_n <= 1'b1;
         ctl <= '{select_low_active: 1'b1, select_high_active: 1'b0,
                  output_gate_n: 1'b1, write_strobe_n: 1'b1};
         req_ready <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= '0;
      end else begin
         req_ready <= (next_state == ST_IDLE);
         rd_valid <= (state == ST_SAMPLE);
         if (state == ST_SAMPLE) begin
            rd_data <= sync2;
         end
         if (accept) begin
            // address set with or before the selects
            word_address <= req.addr[ADDR_W-1:0];
            data_bus_24_out <= req.wdata[DATA_W-1:0];
         end
         // output gate held high during writes: shorter strobe width applies
         ctl.output_gate_n <= !next_gate_open;
         ctl.select_low_active <= !next_selected;
         ctl.select_high_active <= next_selected;
         ctl.write_strobe_n <= !next_strobe_low;
         // strobe rise, select drop and bus release share one edge, zero hold
         data_bus_24_oe_n <= !next_bus_drive;
      end
   end

   // writes are strobe-terminated; address and data stand until that edge
   chk_write_qualified: assert property (@(posedge core_clk) disable iff (reset)
      !ctl.write_strobe_n |-> !ctl.select_low_active && ctl.select_high_active
                              && !data_bus_24_oe_n)
      else $error("strobe low without selects or data driven");

   chk_setup_before_end: assert property (@(posedge core_clk) disable iff (reset)
      $rose(ctl.write_strobe_n) |-> $past(!data_bus_24_oe_n, 2))
      else $error("write data not set up before strobe rise");

   chk_strobe_width: assert property (@(posedge core_clk) disable iff (reset)
      $fell(ctl.write_strobe_n) |-> !ctl.write_strobe_n [*1] ##0
                                    (ctl.output_gate_n throughout 1'b1))
      else $error("strobe pulse too short or gate low");

   chk_addr_stable: assert property (@(posedge core_clk) disable iff (reset)
      !ctl.write_strobe_n || $rose(ctl.write_strobe_n) |-> $stable(word_address))
      else $error("address moved during write");

   chk_release_at_end: assert property (@(posedge core_clk) disable iff (reset)
      $rose(ctl.write_strobe_n) |-> data_bus_24_oe_n && ctl.select_low_active)
      else $error("bus not released with strobe rise");

   chk_read_strobe_high: assert property (@(posedge core_clk) disable iff (reset)
      !ctl.output_gate_n |-> ctl.write_strobe_n && data_bus_24_oe_n)
      else $error("strobe low or bus driven during read");

   chk_read_addr_first: assert property (@(posedge core_clk) disable iff (reset)
      ctl.select_high_active && $past(ctl.select_high_active) |-> $stable(word_address))
      else $error("address changed after select");

   chk_read_sample: assert property (@(posedge core_clk) disable iff (reset)
      $fell(ctl.output_gate_n) |-> !ctl.output_gate_n [*4] ##1 rd_valid)
      else $error("read sampled too early");

   chk_cycle_spacing: assert property (@(posedge core_clk) disable iff (reset)
      $rose(ctl.select_low_active) |-> ctl.select_low_active [*1] ##0 !req_ready)
      else $error("new cycle without spacing");

   // no disable here: these look at the edge right after a reset edge
   chk_reset_selects: assert property (@(posedge core_clk)
      $past(reset) |-> ctl.select_low_active && !ctl.select_high_active
                       && ctl.output_gate_n && ctl.write_strobe_n)
      else $error("pins active after reset edge");

   chk_reset_bus: assert property (@(posedge core_clk)
      $past(reset) |-> data_bus_24_oe_n && !req_ready && !rd_valid)
      else $error("bus driven or handshake high after reset edge");

   chk_select_pair: assert property (@(posedge core_clk) disable iff (reset)
      ctl.select_low_active == !ctl.select_high_active)
      else $error("selects disagree");

   chk_gate_selected: assert property (@(posedge core_clk) disable iff (reset)
      !ctl.output_gate_n |-> !ctl.select_low_active && ctl.select_high_active)
      else $error("output gate open while deselected");

   chk_drive_selected: assert property (@(posedge core_clk) disable iff (reset)
      !data_bus_24_oe_n |-> !ctl.select_low_active && ctl.select_high_active)
      else $error("bus driven while deselected");

   chk_gate_off_write: assert property (@(posedge core_clk) disable iff (reset)
      !data_bus_24_oe_n |-> ctl.output_gate_n)
      else $error("output gate open while host drives");

   chk_strobe_gate_high: assert property (@(posedge core_clk) disable iff (reset)
      !ctl.write_strobe_n |-> ctl.output_gate_n)
      else $error("strobe low with output gate open");

   chk_strobe_one_cycle: assert property (@(posedge core_clk) disable iff (reset)
      $fell(ctl.write_strobe_n) |=> ctl.write_strobe_n)
      else $error("strobe pulse longer than planned");

   chk_strobe_after_setup: assert property (@(posedge core_clk) disable iff (reset)
      $fell(ctl.write_strobe_n) |-> $past(!data_bus_24_oe_n)
                                    && $past(!ctl.select_low_active))
      else $error("strobe fell before selects and data");

   chk_data_stable: assert property (@(posedge core_clk) disable iff (reset)
      !ctl.write_strobe_n |-> $stable(data_bus_24_out))
      else $error("write data moved under strobe");

   chk_data_at_end: assert property (@(posedge core_clk) disable iff (reset)
      $rose(ctl.write_strobe_n) |-> $stable(data_bus_24_out))
      else $error("write data moved at strobe rise");

   chk_ready_idle_pins: assert property (@(posedge core_clk) disable iff (reset)
      req_ready |-> ctl.select_low_active && ctl.output_gate_n
                    && ctl.write_strobe_n && data_bus_24_oe_n)
      else $error("ready while a cycle is open");

   chk_rd_valid_pulse: assert property (@(posedge core_clk) disable iff (reset)
      rd_valid |=> !rd_valid)
      else $error("read valid longer than one cycle");

   chk_rd_valid_closed: assert property (@(posedge core_clk) disable iff (reset)
      rd_valid |-> ctl.select_low_active && ctl.output_gate_n)
      else $error("read answered before cycle closed");

   chk_gap_after_read: assert property (@(posedge core_clk) disable iff (reset)
      $rose(ctl.output_gate_n) |-> !req_ready ##1 req_ready)
      else $error("read gap wrong");

   chk_gap_after_write: assert property (@(posedge core_clk) disable iff (reset)
      $rose(ctl.write_strobe_n) |-> !req_ready ##1 !req_ready ##1 req_ready)
      else $error("write gap wrong");

   chk_read_select_span: assert property (@(posedge core_clk) disable iff (reset)
      $fell(ctl.output_gate_n) |-> !ctl.select_low_active [*4])
      else $error("read select dropped early");

   chk_write_sequence: assert property (@(posedge core_clk) disable iff (reset)
      $fell(ctl.select_low_active) && !data_bus_24_oe_n |->
         ctl.write_strobe_n ##1 !ctl.write_strobe_n ##1 ctl.select_low_active)
      else $error("write sequence out of order");

   chk_release_with_select: assert property (@(posedge core_clk) disable iff (reset)
      $rose(data_bus_24_oe_n) |-> ctl.select_low_active && ctl.write_strobe_n)
      else $error("bus released apart from select drop");

   chk_busy_no_ready: assert property (@(posedge core_clk) disable iff (reset)
      !ctl.select_low_active |-> !req_ready)
      else $error("ready while selected");
endmodule
`default_nettype wire

// file: tb/sram24_model.sv
// behavioural 128K x 24 static memory facing the host controller
// assumes the bench resolves the shared data bus and feeds it back here
`timescale 1ns/100ps
`default_nettype none
module sram24_model (
   input wire logic [16:0] word_address,
   input wire sram24_pkg::sram_ctl_s ctl,
   input wire logic [23:0] bus,
   output logic [23:0] q,
   output logic drv,
   output int viol
);
   logic [23:0] mem [0:131071];
   logic [23:0] wd;
   logic [16:0] wa;
   realtime t_sel = -100.0;
   wire sel = !ctl.select_low_active && ctl.select_high_active;
   wire wr = sel && !ctl.write_strobe_n;
   assign drv = sel && ctl.write_strobe_n && !ctl.output_gate_n;
   initial viol = 0;
   always @(posedge sel) begin
      if ($realtime - t_sel < 10.0) viol++;
      t_sel = $realtime;
   end
   always @(posedge wr) begin
      #1 wd = bus;
      wa = word_address;
      #7 if (bus !== wd || word_address !== wa || wr !== 1'h1) viol++;
   end
   // commit at the terminating edge, so data dropped after it is never stored
   always @(negedge wr) mem[wa] = wd;
   // during the access time the old word shows inverted, never as valid data
   always @(word_address or drv) begin
      q = ~q;
      q <= #10 mem[word_address];
   end
endmodule
`default_nettype wire

// file: tb/tb_async_sram_24bit_access.sv
// self-checking bench for the static memory host controller
// assumes the memory model in sram24_model and a 100 MHz core clock
`timescale 1ns/100ps
`default_nettype none
module tb_async_sram_24bit_access;
   typedef struct packed {
      logic w;
      logic [16:0] a;
      logic [23:0] d;
   } row_s;
   logic core_clk = 1'h0;
   logic reset = 1'h1;
   logic req_valid = 1'h0;
   sram24_pkg::sram_req_s req = '0;
   logic req_ready, rd_valid, oe_n, drv;
   logic [23:0] rd_data, dout, q, bus;
   logic [16:0] word_address;
   logic [7:0] pat = 8'h00;
   sram24_pkg::sram_ctl_s ctl;
   int viol, n;
   int err_count = 0;
   int cmp_count = 0;
   row_s rows [8] = '{
      '{1'h1, 17'h00000, 24'hAAAAAA}, '{1'h1, 17'h1FFFF, 24'h555555},
      '{1'h1, 17'h00001, 24'hFFFFFF}, '{1'h0, 17'h00000, 24'hAAAAAA},
      '{1'h0, 17'h1FFFF, 24'h555555}, '{1'h0, 17'h00001, 24'hFFFFFF},
      '{1'h1, 17'h00000, 24'h000000}, '{1'h0, 17'h00000, 24'h000000}};
   // a released bus changes every cycle so a stale word never reads as valid
   assign bus = !oe_n ? dout : drv ? q : {3{pat}};
   sram24_host i_dut (.core_clk(core_clk), .reset(reset), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
      .word_address(word_address), .ctl(ctl), .data_bus_24_in(bus),
      .data_bus_24_out(dout), .data_bus_24_oe_n(oe_n));
   sram24_model i_mem (.word_address(word_address), .ctl(ctl), .bus(bus), .q(q), .drv(drv),
      .viol(viol));
   initial forever #5 core_clk = ~core_clk;
   always @(posedge core_clk) pat <= pat + 8'h01;
   always @(posedge core_clk) if (!oe_n && drv) fail("bus contention");
   task fail(input string m);
      err_count++;
      $display("unexpected %0t %s", $time, m);
   endtask
   task chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'h1) fail(m);
   endtask
   task results;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic take(input row_s r);
      // one clear edge between two calls so valid is never set twice in one step
      @(negedge core_clk);
      n = 0;
      req = {r.w, r.a, r.d};
      req_valid = 1'h1;
      while (req_ready !== 1'h1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      @(negedge core_clk);
      req_valid = 1'h0;
      chk(req_ready === 1'h0, "ready while busy");
   endtask
   task automatic op(input row_s r);
      take(r);
      n = 0;
      if (!r.w) begin
         while (rd_valid !== 1'h1 && n < 9) begin
            chk(ctl.write_strobe_n === 1'h1, "strobe low in read");
            @(negedge core_clk);
            n++;
         end
         chk(n == sram24_pkg::READ_CYC + 3 && rd_data === r.d, "read word");
      end
   endtask
   initial begin
      repeat (16) @(negedge core_clk);
      chk(ctl === 4'hB && oe_n === 1'h1 && req_ready === 1'h0 && rd_valid === 1'h0, "reset");
      reset = 1'h0;
      @(negedge core_clk);
      chk(req_ready === 1'h1, "ready after reset");
      foreach (rows[i]) op(rows[i]);
      // a reset in mid-read must drop the pins and lose the answer
      take(rows[4]);
      repeat (2) @(negedge core_clk);
      reset = 1'h1;
      @(negedge core_clk);
      chk(ctl === 4'hB && oe_n === 1'h1 && rd_valid === 1'h0, "pins in reset");
      reset = 1'h0;
      n = 0;
      repeat (8) begin
         @(negedge core_clk);
         if (rd_valid === 1'h1) n++;
      end
      chk(n == 0, "answer after reset");
      op(rows[5]);
      chk(viol == 0, "memory timing");
      results;
   end
   initial begin
      #5000;
      fail("timeout");
      results;
   end
endmodule
`default_nettype wire
